/* File: src/fpr_pcs_rx.sv */
// 100Base-X receive coding path with transmit cipher and status registers
// assumes line bits and MAC inputs synchronous to clk_sys, Avalon-MM master
//
// The Avalon-MM slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "fpr_params.svh"
module fpr_pcs_rx
    import fpr_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // line side receive
    input  wire logic        line_rx_nrzi,
    input  wire logic        line_rx_valid,
    input  wire logic        line_signal_detect,
    input  wire logic        line_pll_lock,
    // line side transmit
    input  wire logic        tx_bit,
    input  wire logic        tx_bit_valid,
    output logic             tx_line_bit_reg,
    output logic             tx_line_valid_reg,
    // MAC side
    input  wire logic        mac_tx_er,
    input  wire logic [4:0]  phy_address,
    output logic [3:0]       mac_rxd_reg,
    output logic             mac_rx_strobe_reg,
    output logic             mac_rx_dv_reg,
    output logic             mac_rx_er_reg,
    output logic             mac_crs_reg,
    output logic             tx_force_invalid_reg,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest
);
    localparam int CW = `FPR_CIPHER_W;

    fpr_rx_state_type  state_reg;
    fpr_rx_state_type  state_next;
    fpr_sym_class_type sym_class;
    logic [3:0]        sym_nibble;

    logic              nrzi_prev_reg;
    logic              plain_bit;
    logic              bin_bit;
    logic              bit_valid_reg;
    logic              bit_reg;
    logic [9:0]        window_reg;
    logic [CW-1:0]     raw_reg;
    logic [3:0]        raw_cnt_reg;
    logic              descr_locked_reg;
    logic [CW-1:0]     rx_key_state;
    logic [CW-1:0]     tx_key_state;
    logic              rx_load;
    logic              tx_seeded_reg;
    logic              bypass;

    logic [2:0]        sym_cnt_reg;
    logic [3:0]        hunt_cnt_reg;
    logic [4:0]        sym_reg;
    logic              sym_ready;
    logic              gap_one_reg;
    logic              zero_seen_reg;
    logic              t_seen_reg;
    logic              carrier_hit;
    logic              jk_hit;
    logic              link_ok;

    logic              ctrl_tx_invalid_reg;
    logic [1:0]        mode_reg;
    logic              lh_premature_reg;
    logic              lh_halt_reg;
    logic              lh_invalid_reg;
    logic              lh_lock_err_reg;
    logic              ll_link_reg;
    logic              ev_premature;
    logic              ev_halt;
    logic              ev_invalid;
    logic              bus_take;
    logic              rd_done17;
    logic              rd_done1;
    logic              wr_done;

    assign bypass = mode_reg[`FPR_BM_SYMBOL_MODE] | ~mode_reg[`FPR_BM_SCRAMBLE_EN];
    assign link_ok = line_signal_detect & line_pll_lock;

    // line bit recovery
    assign bin_bit = line_rx_nrzi ^ nrzi_prev_reg;
    assign plain_bit = bypass ? bin_bit
                     : bin_bit ^ (rx_key_state[CW-1] ^ rx_key_state[CW-3]);
    assign rx_load = line_rx_valid & ~descr_locked_reg & (raw_cnt_reg == 4'(CW));

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            nrzi_prev_reg <= 1'h0;
            bit_valid_reg <= 1'h0;
            bit_reg       <= 1'h1;
        end
        else
        begin
            bit_valid_reg <= line_rx_valid;
            if (line_rx_valid)
            begin
                nrzi_prev_reg <= line_rx_nrzi;
                bit_reg       <= plain_bit;
            end
        end
    end

    // descrambler lock: idle is all ones, so the key is the inverted line
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            raw_reg          <= {CW{1'b0}};
            raw_cnt_reg      <= 4'h0;
            descr_locked_reg <= 1'h0;
        end
        else if (~line_signal_detect)
        begin
            raw_cnt_reg      <= 4'h0;
            descr_locked_reg <= 1'h0;
        end
        else if (line_rx_valid)
        begin
            raw_reg <= {raw_reg[CW-2:0], bin_bit};
            if (rx_load)
            begin
                descr_locked_reg <= 1'h1;
            end
            else if (~descr_locked_reg)
            begin
                raw_cnt_reg <= raw_cnt_reg + 4'h1;
            end
        end
    end

    fpr_cipher #(.W(CW)) u_rx_cipher
    (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .step       (line_rx_valid & descr_locked_reg),
        .load       (rx_load),
        .load_value (~raw_reg),
        .state_reg  (rx_key_state)
    );

    // transmit scrambler, seeded from the PHY address after reset
    fpr_cipher #(.W(CW)) u_tx_cipher
    (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .step       (tx_bit_valid & tx_seeded_reg),
        .load       (~tx_seeded_reg),
        .load_value ({`FPR_SEED_FILL, phy_address}),
        .state_reg  (tx_key_state)
    );

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            tx_seeded_reg        <= 1'h0;
            tx_line_bit_reg      <= 1'h1;
            tx_line_valid_reg    <= 1'h0;
            tx_force_invalid_reg <= 1'h0;
        end
        else
        begin
            tx_seeded_reg        <= 1'h1;
            tx_line_valid_reg    <= tx_bit_valid;
            tx_force_invalid_reg <= ctrl_tx_invalid_reg & mac_tx_er;
            if (tx_bit_valid)
            begin
                tx_line_bit_reg <= bypass ? tx_bit
                                 : tx_bit ^ (tx_key_state[CW-1] ^ tx_key_state[CW-3]);
            end
        end
    end

    // bit window and symbol framing
    assign carrier_hit = bit_valid_reg & ~bit_reg & gap_one_reg & zero_seen_reg;
    assign jk_hit = bit_valid_reg & ({window_reg[8:0], bit_reg} == `FPR_JK_PAIR);
    assign sym_ready = bit_valid_reg & (sym_cnt_reg == 3'h4);

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            window_reg    <= 10'h3FF;
            zero_seen_reg <= 1'h0;
            gap_one_reg   <= 1'h0;
        end
        else if (bit_valid_reg)
        begin
            window_reg <= {window_reg[8:0], bit_reg};
            if (state_reg == FPR_ST_IDLE)
            begin
                zero_seen_reg <= (zero_seen_reg | ~bit_reg) & ~carrier_hit;
                gap_one_reg   <= zero_seen_reg & bit_reg;
            end
            else
            begin
                zero_seen_reg <= 1'h0;
                gap_one_reg   <= 1'h0;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            sym_cnt_reg <= 3'h0;
            sym_reg     <= `FPR_C_I;
        end
        else if (state_reg == FPR_ST_IDLE || state_reg == FPR_ST_CARRIER)
        begin
            sym_cnt_reg <= 3'h0;
        end
        else if (bit_valid_reg)
        begin
            sym_cnt_reg <= sym_ready ? 3'h0 : sym_cnt_reg + 3'h1;
            if (sym_ready)
            begin
                sym_reg <= {window_reg[3:0], bit_reg};
            end
        end
    end

    // 4B/5B classification and decoding
    always_comb
    begin
        sym_class  = FPR_SYM_DATA;
        sym_nibble = 4'h0;
        case (sym_reg)
            5'h1E: sym_nibble = 4'h0;
            5'h09: sym_nibble = 4'h1;
            5'h14: sym_nibble = 4'h2;
            5'h15: sym_nibble = 4'h3;
            5'h0A: sym_nibble = 4'h4;
            5'h0B: sym_nibble = 4'h5;
            5'h0E: sym_nibble = 4'h6;
            5'h0F: sym_nibble = 4'h7;
            5'h12: sym_nibble = 4'h8;
            5'h13: sym_nibble = 4'h9;
            5'h16: sym_nibble = 4'hA;
            5'h17: sym_nibble = 4'hB;
            5'h1A: sym_nibble = 4'hC;
            5'h1B: sym_nibble = 4'hD;
            5'h1C: sym_nibble = 4'hE;
            5'h1D: sym_nibble = 4'hF;
            `FPR_C_I: sym_class = FPR_SYM_IDLE;
            `FPR_C_J: sym_class = FPR_SYM_JK;
            `FPR_C_K: sym_class = FPR_SYM_JK;
            `FPR_C_T: sym_class = FPR_SYM_T;
            `FPR_C_R: sym_class = FPR_SYM_R;
            `FPR_C_H: sym_class = FPR_SYM_HALT;
            default:  sym_class = FPR_SYM_INVALID;
        endcase
    end

    // receive machine
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            FPR_ST_IDLE:
            begin
                if (carrier_hit)
                begin
                    state_next = FPR_ST_CARRIER;
                end
            end
            FPR_ST_CARRIER:
            begin
                if (jk_hit)
                begin
                    state_next = FPR_ST_RECV;
                end
                else if (bit_valid_reg && hunt_cnt_reg == `FPR_HUNT_BITS)
                begin
                    state_next = FPR_ST_IDLE;
                end
            end
            FPR_ST_RECV:
            begin
                if (sym_ready)
                begin
                    state_next = FPR_ST_DATA;
                end
            end
            FPR_ST_DATA:
            begin
                if (sym_class == FPR_SYM_IDLE || (t_seen_reg && sym_class == FPR_SYM_R))
                begin
                    state_next = FPR_ST_IDLE;
                end
                else if (sym_class == FPR_SYM_T && !t_seen_reg)
                begin
                    state_next = FPR_ST_END;
                end
                else
                begin
                    state_next = FPR_ST_RECV;
                end
            end
            FPR_ST_END:
            begin
                if (sym_ready)
                begin
                    state_next = FPR_ST_DATA;
                end
            end
            default: state_next = FPR_ST_IDLE;
        endcase
        if (!link_ok)
        begin
            state_next = FPR_ST_IDLE;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_reg    <= FPR_ST_IDLE;
            hunt_cnt_reg <= 4'h0;
            t_seen_reg   <= 1'h0;
        end
        else
        begin
            state_reg <= state_next;
            if (state_reg != FPR_ST_CARRIER)
            begin
                hunt_cnt_reg <= 4'h0;
            end
            else if (bit_valid_reg)
            begin
                hunt_cnt_reg <= hunt_cnt_reg + 4'h1;
            end
            if (state_reg == FPR_ST_DATA)
            begin
                t_seen_reg <= (sym_class == FPR_SYM_T) & ~t_seen_reg;
            end
        end
    end

    // symbol events
    assign ev_premature = (state_reg == FPR_ST_DATA) && (sym_class == FPR_SYM_IDLE);
    assign ev_halt      = (state_reg == FPR_ST_DATA) && (sym_class == FPR_SYM_HALT);
    assign ev_invalid   = (state_reg == FPR_ST_DATA) && (sym_class == FPR_SYM_INVALID);

    // MAC outputs
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            mac_rxd_reg       <= 4'h0;
            mac_rx_strobe_reg <= 1'h0;
            mac_rx_dv_reg     <= 1'h0;
            mac_rx_er_reg     <= 1'h0;
            mac_crs_reg       <= 1'h0;
        end
        else
        begin
            mac_rx_strobe_reg <= 1'h0;
            mac_rx_er_reg     <= 1'h0;
            mac_crs_reg       <= (state_next != FPR_ST_IDLE);
            if (state_reg == FPR_ST_CARRIER && state_next == FPR_ST_RECV)
            begin
                mac_rxd_reg       <= `FPR_PREAMBLE_NIB;
                mac_rx_strobe_reg <= 1'h1;
                mac_rx_dv_reg     <= 1'h1;
            end
            else if (state_reg == FPR_ST_CARRIER && state_next == FPR_ST_IDLE)
            begin
                mac_rx_er_reg <= 1'h1;
            end
            else if (state_reg == FPR_ST_RECV && mac_rx_dv_reg && sym_cnt_reg == 3'h0
                     && hunt_cnt_reg == 4'h0 && !mac_rx_strobe_reg && bit_valid_reg
                     && mac_rxd_reg == `FPR_PREAMBLE_NIB && !t_seen_reg
                     && window_reg == `FPR_JK_PAIR)
            begin
                mac_rx_strobe_reg <= 1'h1;
            end
            else if (state_reg == FPR_ST_DATA)
            begin
                if (t_seen_reg && sym_class == FPR_SYM_R)
                begin
                    mac_rx_dv_reg <= 1'h0;
                end
                else if (ev_premature)
                begin
                    mac_rx_er_reg <= 1'h1;
                    mac_rx_dv_reg <= 1'h0;
                end
                else if (sym_class == FPR_SYM_DATA && !t_seen_reg)
                begin
                    mac_rxd_reg       <= sym_nibble;
                    mac_rx_strobe_reg <= 1'h1;
                end
                else if (sym_class != FPR_SYM_T || t_seen_reg)
                begin
                    mac_rx_er_reg     <= 1'h1;
                    mac_rx_strobe_reg <= 1'h1;
                end
            end
            if (!link_ok)
            begin
                mac_rx_dv_reg <= 1'h0;
            end
        end
    end

    // Avalon-MM slave, one wait cycle per access
    assign bus_take  = (avs_read | avs_write) & avs_waitrequest;
    assign rd_done17 = avs_read & ~avs_waitrequest & (avs_address == `FPR_OFS_STAT17);
    assign rd_done1  = avs_read & ~avs_waitrequest & (avs_address == `FPR_OFS_STAT1);
    assign wr_done   = avs_write & ~avs_waitrequest;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            avs_waitrequest <= 1'h1;
            avs_readdata    <= 32'h0;
        end
        else
        begin
            avs_waitrequest <= ~bus_take;
            if (bus_take && avs_read)
            begin
                case (avs_address)
                    `FPR_OFS_STAT17: avs_readdata <= {22'h0, lh_lock_err_reg, 1'h0,
                        lh_invalid_reg, lh_halt_reg, lh_premature_reg, 4'h0, link_ok};
                    `FPR_OFS_STAT1:  avs_readdata <= {29'h0, ll_link_reg, 2'h0};
                    `FPR_OFS_CTRL16: avs_readdata <= {29'h0, ctrl_tx_invalid_reg, 2'h0};
                    `FPR_OFS_MODE:   avs_readdata <= {30'h0, mode_reg};
                    default:         avs_readdata <= 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ctrl_tx_invalid_reg <= `FPR_CTRL16_RST;
            mode_reg            <= `FPR_MODE_RST;
        end
        else if (wr_done)
        begin
            if (avs_address == `FPR_OFS_CTRL16)
            begin
                ctrl_tx_invalid_reg <= avs_writedata[`FPR_B16_TX_INVALID];
            end
            if (avs_address == `FPR_OFS_MODE)
            begin
                mode_reg <= avs_writedata[1:0];
            end
        end
    end

    // sticky status; a new event wins over the read clear
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            lh_premature_reg <= 1'h0;
            lh_halt_reg      <= 1'h0;
            lh_invalid_reg   <= 1'h0;
            lh_lock_err_reg  <= 1'h0;
            ll_link_reg      <= 1'h0;
        end
        else
        begin
            lh_premature_reg <= ev_premature | (lh_premature_reg & ~rd_done17);
            lh_halt_reg      <= ev_halt | (lh_halt_reg & ~rd_done17);
            lh_invalid_reg   <= ev_invalid | (lh_invalid_reg & ~rd_done17);
            lh_lock_err_reg  <= ~line_pll_lock | (lh_lock_err_reg & ~rd_done17);
            ll_link_reg      <= link_ok & (ll_link_reg | rd_done1);
        end
    end
endmodule // fpr_pcs_rx

/* File: src/fpr_params.svh */
// constants for the 100Base-X receive coding path: offsets, fields, codes
// assumes inclusion by the design modules, the checker and the bench
`ifndef FPR_PARAMS_SVH
`define FPR_PARAMS_SVH

// register byte offsets
`define FPR_OFS_STAT17       4'h0
`define FPR_OFS_STAT1        4'h4
`define FPR_OFS_CTRL16       4'h8
`define FPR_OFS_MODE         4'hC

// status 17 field positions
`define FPR_B17_LINK         0
`define FPR_B17_PREMATURE    5
`define FPR_B17_HALT         6
`define FPR_B17_INVALID      7
`define FPR_B17_LOCK_ERR     9
// status 1 and control fields
`define FPR_B1_LINK          2
`define FPR_B16_TX_INVALID   2
`define FPR_BM_SYMBOL_MODE   0
`define FPR_BM_SCRAMBLE_EN   1

// reset values
`define FPR_CTRL16_RST       1'h0
`define FPR_MODE_RST         2'h2

// cipher
`define FPR_CIPHER_W         11
`define FPR_SEED_FILL        6'h3F

// carrier hunt: bits allowed to complete J K after carrier detect
`define FPR_HUNT_BITS        4'hA
`define FPR_PREAMBLE_NIB     4'h5

// 5-bit code groups, first line bit is the msb
`define FPR_C_I              5'h1F
`define FPR_C_J              5'h18
`define FPR_C_K              5'h11
`define FPR_C_T              5'h0D
`define FPR_C_R              5'h07
`define FPR_C_H              5'h04
`define FPR_JK_PAIR          10'h311

`endif

/* File: src/fpr_pkg.sv */
// types for the 100Base-X receive coding path
// assumes fpr_params.svh beside it
package fpr_pkg;

    // receive machine, one-hot
    typedef enum logic [4:0]
    {
        FPR_ST_IDLE    = 5'h01,
        FPR_ST_CARRIER = 5'h02,
        FPR_ST_RECV    = 5'h04,
        FPR_ST_DATA    = 5'h08,
        FPR_ST_END     = 5'h10
    } fpr_rx_state_type;

    // symbol classes
    typedef enum logic [2:0]
    {
        FPR_SYM_DATA    = 3'h0,
        FPR_SYM_IDLE    = 3'h1,
        FPR_SYM_T       = 3'h2,
        FPR_SYM_R       = 3'h3,
        FPR_SYM_HALT    = 3'h4,
        FPR_SYM_INVALID = 3'h5,
        FPR_SYM_JK      = 3'h6
    } fpr_sym_class_type;

endpackage

/* File: src/fpr_cipher.sv */
// stream cipher shift register, x^11 + x^9 + 1
// assumes caller steps it once per line bit and may load a full state
`timescale 1ns/10ps
`include "fpr_params.svh"
module fpr_cipher
#(
    parameter int W = `FPR_CIPHER_W
)
(
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // control
    input  wire logic         step,
    input  wire logic         load,
    input  wire logic [W-1:0] load_value,
    // state
    output logic      [W-1:0] state_reg
);
    logic [W-1:0] state_next;

    always_comb
    begin
        state_next = state_reg;
        if (load)
        begin
            state_next = load_value;
        end
        else if (step)
        begin
            state_next = {state_reg[W-2:0], state_reg[W-1] ^ state_reg[W-3]};
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_reg <= {W{1'b1}};
        end
        else
        begin
            state_reg <= state_next;
        end
    end
endmodule // fpr_cipher

/* File: sim/fpr_pcs_rx_sva.sv */
// assertions on the receive coding path ports
// assumes a bind onto fpr_pcs_rx, one clk_sys domain
`timescale 1ns/10ps
`include "fpr_params.svh"
module fpr_pcs_rx_sva
(
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       rst,
    // line and mac
    input wire logic       line_signal_detect,
    input wire logic       line_pll_lock,
    input wire logic       mac_tx_er,
    input wire logic [3:0] mac_rxd_reg,
    input wire logic       mac_rx_strobe_reg,
    input wire logic       mac_rx_dv_reg,
    input wire logic       mac_rx_er_reg,
    input wire logic       mac_crs_reg,
    input wire logic       tx_force_invalid_reg,
    // bus
    input wire logic       avs_read,
    input wire logic       avs_write,
    input wire logic       avs_waitrequest
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence s_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    property p_rst;
        $fell(rst) |-> !mac_crs_reg && !mac_rx_dv_reg && avs_waitrequest;
    endproperty
    a_rst: assert property (p_rst) else $error("active after reset");
    property p_pre;
        $rose(mac_rx_dv_reg) |-> mac_rx_strobe_reg && mac_rxd_reg == `FPR_PREAMBLE_NIB;
    endproperty
    a_pre: assert property (p_pre) else $error("no preamble nibble");
    property p_crs;
        $rose(mac_rx_dv_reg) |-> $past(mac_crs_reg);
    endproperty
    a_crs: assert property (p_crs) else $error("frame without carrier");
    property p_frm;
        mac_rx_strobe_reg && !mac_rx_er_reg |-> mac_rx_dv_reg;
    endproperty
    a_frm: assert property (p_frm) else $error("nibble outside frame");
    property p_prem;
        mac_rx_er_reg && !mac_rx_dv_reg |-> ##[0:20] !mac_crs_reg;
    endproperty
    a_prem: assert property (p_prem) else $error("carrier stays on");
    property p_flt;
        !(line_signal_detect && line_pll_lock) |-> ##[1:4] !mac_rx_dv_reg;
    endproperty
    a_flt: assert property (p_flt) else $error("frame during link fault");
    property p_frc;
        !$past(mac_tx_er) |-> !tx_force_invalid_reg;
    endproperty
    a_frc: assert property (p_frc) else $error("invalid code unasked");
    property p_bus;
        (avs_read || avs_write) && avs_waitrequest |=> s_ack;
    endproperty
    a_bus: assert property (p_bus) else $error("bus answer late");
endmodule // fpr_pcs_rx_sva

bind fpr_pcs_rx fpr_pcs_rx_sva i_fpr_pcs_rx_sva (.clk_sys, .rst, .line_signal_detect,
    .line_pll_lock, .mac_tx_er, .mac_rxd_reg, .mac_rx_strobe_reg, .mac_rx_dv_reg,
    .mac_rx_er_reg, .mac_crs_reg, .tx_force_invalid_reg, .avs_read, .avs_write,
    .avs_waitrequest);

/* File: sim/fpr_mac_model.sv */
// mac model: logs good nibbles, counts error pulses, drives tx error
// assumes phy receive outputs registered on clk_sys
`timescale 1ns/10ps
module fpr_mac_model
(
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       rst,
    // phy receive side
    input wire logic [3:0] mac_rxd_reg,
    input wire logic       mac_rx_strobe_reg,
    input wire logic       mac_rx_er_reg,
    // bench side
    input wire logic       tx_er_req,
    output logic           mac_tx_er,
    output logic [63:0]    nib_log,
    output logic [3:0]     er_cnt
);
    assign mac_tx_er = tx_er_req;
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            nib_log <= 64'h0;
            er_cnt  <= 4'h0;
        end
        else if (mac_rx_er_reg)
            er_cnt <= er_cnt + 4'h1;
        else if (mac_rx_strobe_reg)
            nib_log <= {nib_log[59:0], mac_rxd_reg};
    end
endmodule // fpr_mac_model

/* File: sim/tb_top.sv */
// bench: line bits, mac model and bus accesses with checks
// assumes design under src/, model and checker under sim/
`timescale 1ns/10ps
`include "fpr_params.svh"
module tb_top;
    logic        clk_sys, rst, line_rx_nrzi, line_rx_valid, line_signal_detect;
    logic        line_pll_lock, tx_bit, tx_bit_valid, mac_tx_er, tx_er_req;
    logic        tx_line_bit_reg, tx_line_valid_reg, mac_rx_strobe_reg, mac_rx_dv_reg;
    logic        mac_rx_er_reg, mac_crs_reg, tx_force_invalid_reg, lvl;
    logic        avs_read, avs_write, avs_waitrequest;
    logic [3:0]  mac_rxd_reg, avs_address, er_cnt, ere;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [63:0] nib_log;
    logic [4:0]  dcode [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                                5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    int          fail_count, checks;

    fpr_pcs_rx i_fpr_pcs_rx (.clk_sys, .rst, .line_rx_nrzi, .line_rx_valid,
        .line_signal_detect, .line_pll_lock, .tx_bit, .tx_bit_valid, .tx_line_bit_reg,
        .tx_line_valid_reg, .mac_tx_er, .phy_address(5'h05), .mac_rxd_reg,
        .mac_rx_strobe_reg, .mac_rx_dv_reg, .mac_rx_er_reg, .mac_crs_reg,
        .tx_force_invalid_reg, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest);
    fpr_mac_model i_fpr_mac_model (.clk_sys, .rst, .mac_rxd_reg, .mac_rx_strobe_reg,
        .mac_rx_er_reg, .tx_er_req, .mac_tx_er, .nib_log, .er_cnt);

    task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
        checks++;
        if (s !== e)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic av(input logic [3:0] a, input logic w, input logic [31:0] d);
        int i;
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        i = 0;
        do
        begin
            @(posedge clk_sys);
            i++;
        end
        while (avs_waitrequest !== 1'b0 && i < 50);
        q = avs_readdata;
        if (i == 50)
        begin
            fail_count++;
            give_verdict();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic sb(input logic b);
        lvl = lvl ^ b;
        line_rx_nrzi <= lvl;
        line_rx_valid <= 1'b1;
        @(posedge clk_sys);
        line_rx_valid <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic sym(input logic [4:0] c);
        for (int i = 4; i >= 0; i--)
            sb(c[i]);
    endtask
    task automatic frame(input logic [4:0] mid, input logic tr);
        sym(`FPR_C_J);
        sym(`FPR_C_K);
        for (int i = 1; i < 16; i++)
            sym(dcode[i]);
        sym(mid);
        if (tr)
        begin
            sym(`FPR_C_T);
            sym(`FPR_C_R);
        end
        repeat (4)
            sym(`FPR_C_I);
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever
            #2 clk_sys = ~clk_sys;
    end
    initial
    begin
        repeat (100000)
            @(posedge clk_sys);
        fail_count++;
        give_verdict();
    end
    initial
    begin
        {rst, line_signal_detect, line_pll_lock, lvl, line_rx_nrzi} = 5'h1C;
        {line_rx_valid, tx_bit, tx_bit_valid, tx_er_req, avs_read, avs_write} = 6'h00;
        {avs_address, ere, avs_writedata} = 40'h0;
        repeat (16)
            @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        av(4'hC, 0, 0);
        chk("mode", q, `FPR_MODE_RST);
        av(4'h2, 0, 0);
        chk("unmapped", q, 0);
        av(4'hC, 1, 1);
        $display("regs done");
        repeat (20)
            sb(1);
        frame(dcode[0], 1);
        chk("nibbles", nib_log, 64'h123456789ABCDEF0);
        chk("errors", er_cnt, ere);
        chk("dv", mac_rx_dv_reg, 0);
        $display("frame done");
        for (int k = 0; k < 2; k++)
        begin
            frame(k ? 5'h02 : `FPR_C_H, 1);
            ere++;
            chk("sym err", er_cnt, ere);
            av(4'h0, 0, 0);
            chk("st17", q[k ? `FPR_B17_INVALID : `FPR_B17_HALT], 1);
        end
        frame(dcode[0], 0);
        ere++;
        chk("prem err", er_cnt, ere);
        av(4'h0, 0, 0);
        chk("prem bit", q[`FPR_B17_PREMATURE], 1);
        av(4'h0, 0, 0);
        chk("cleared", q[`FPR_B17_PREMATURE], 0);
        sym(5'h15);
        repeat (12)
            sb(1);
        ere++;
        chk("hunt err", er_cnt, ere);
        chk("crs", mac_crs_reg, 0);
        $display("errors done");
        av(4'h4, 0, 0);
        av(4'h4, 0, 0);
        chk("link up", q[`FPR_B1_LINK], 1);
        line_pll_lock <= 1'b0;
        repeat (4)
            @(posedge clk_sys);
        av(4'h0, 0, 0);
        chk("lock err", q[`FPR_B17_LOCK_ERR], 1);
        chk("link17", q[`FPR_B17_LINK], 0);
        av(4'h4, 0, 0);
        chk("link1", q[`FPR_B1_LINK], 0);
        line_pll_lock <= 1'b1;
        av(4'h0, 0, 0);
        chk("held", q[`FPR_B17_LOCK_ERR], 1);
        av(4'h0, 0, 0);
        chk("released", q[`FPR_B17_LOCK_ERR], 0);
        $display("link done");
        for (int k = 0; k < 2; k++)
        begin
            tx_bit <= k[0];
            tx_bit_valid <= 1'b1;
            @(posedge clk_sys);
            tx_bit_valid <= 1'b0;
            @(posedge clk_sys);
            chk("tx bypass", tx_line_bit_reg, k[0]);
        end
        tx_er_req <= 1'b1;
        repeat (3)
            @(posedge clk_sys);
        chk("no force", tx_force_invalid_reg, 0);
        av(4'h8, 1, 32'h1 << `FPR_B16_TX_INVALID);
        repeat (3)
            @(posedge clk_sys);
        chk("force", tx_force_invalid_reg, 1);
        $display("tx done");
        give_verdict();
    end
endmodule // tb_top
